// ### core/link_if.sv
`timescale 1ns/1ps
`default_nettype none
// link-domain events handed to the core domain as levels that clear with the frame
interface link_if;
  logic req_lvl;   // shutdown requested at 10th falling edge
  logic start_lvl; // a new burst of shift clocks began
  logic tick_lvl;  // flips on each shift clock after the tenth
  modport link (output req_lvl, output start_lvl, output tick_lvl);
  modport core (input req_lvl, input start_lvl, input tick_lvl);
endinterface : link_if
`default_nettype wire

// ### core/link_side.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwrdn_regs.svh"
// shift-clock domain: collect input word, count edges, flag events
module link_side
  import pwrdn_pkg::*;
(
  // link pins
  input  wire logic i_sclk,
  input  wire logic i_cs_n,
  input  wire logic i_din,
  // to core domain
  link_if.link      lnk
);
  typedef struct packed {
    logic [`PWRDN_WORD_BITS-1:0] sh;
    logic [4:0]                  cnt;
    logic                        req_lvl;
    logic                        start_lvl;
    logic                        tick_lvl;
  } lstate_t;

  lstate_t s_q;
  lstate_t s_d;

  // a raised chip select clears the frame; no clock edge is counted on outside frames
  always_comb begin
    s_d = s_q;
    if (!i_cs_n) begin
      if (s_q.cnt < 5'd31)
        s_d.cnt = s_q.cnt + 5'd1;
      if (s_q.cnt < 5'(`PWRDN_WORD_BITS))
        s_d.sh = {s_q.sh[`PWRDN_WORD_BITS-2:0], i_din};
      if (s_q.cnt == 5'd0)
        s_d.start_lvl = 1'b1;
      // clocks beyond the tenth keep flipping so the core can see a burst still running
      if (s_q.cnt >= `PWRDN_ENTER_EDGE)
        s_d.tick_lvl = ~s_q.tick_lvl;
      // shutdown decode on word-length field, taken at the 10th falling edge
      if (s_q.cnt == `PWRDN_ENTER_EDGE - 5'd1 &&
          s_q.sh[`PWRDN_WL_UPPER_POS] == `PWRDN_WL_UPPER_CODE &&
          s_q.sh[`PWRDN_WL_LOWER_POS] == `PWRDN_WL_LOWER_CODE)
        s_d.req_lvl = 1'b1;
    end
  end

  // raised chip select clears the frame; levels stay up at least a quarter clock,
  // longer than one core period, so the core always samples them
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.req_lvl   = s_q.req_lvl;
  assign lnk.start_lvl = s_q.start_lvl;
  assign lnk.tick_lvl  = s_q.tick_lvl;
endmodule : link_side
`default_nettype wire

// ### core/pwr_shutdown_ctrl.sv
// Contract
// - word-length bits upper 0, lower 1 mean shutdown, not an output length.
// - wake on next conversion request and convert at once, no added delay.
// - conversion request is chip select falling, or new shift burst under low select.
// - enter shutdown at the falling edge of the tenth shift clock.
// - on shutdown run one dummy conversion, then idle until next request.
// - shift clocks still running after dummy conversion count as a request.
`timescale 1ns/1ps
`default_nettype none
`include "pwrdn_regs.svh"
module pwr_shutdown_ctrl
  import pwrdn_pkg::*;
#(
  parameter logic [7:0] DUMMY_CYCLES = `PWRDN_DUMMY_CYCLES
) (
  // core clock and reset
  input  wire logic i_mclk,
  input  wire logic i_srst,
  // link pins from the host serial port
  input  wire logic i_sclk,
  input  wire logic i_cs_n,
  input  wire logic i_din,
  // conversion clock pin, sampled
  input  wire logic i_aclk,
  // status
  output logic      o_powered,
  output logic      o_dummy_busy,
  output logic      o_conv_req
);
  link_if lnk ();

  link_side u_link (
    .i_sclk (i_sclk),
    .i_cs_n (i_cs_n),
    .i_din  (i_din),
    .lnk    (lnk)
  );

  typedef struct packed {
    logic [1:0] req_sync;
    logic [1:0] start_sync;
    logic [1:0] cs_sync;
    logic [1:0] aclk_sync;
    logic [1:0] tick_sync;
    logic       tick_prev;
    logic       req_prev;
    logic       start_prev;
    logic       cs_prev;
    logic       aclk_prev;
    pwr_state_t st;
    logic [7:0] dcnt;
    logic       conv_req;
    logic       pend_start;
  } cstate_t;

  cstate_t c_q;
  cstate_t c_d;

  logic req_evt;
  logic start_evt;
  logic cs_fall;
  logic aclk_rise;
  logic tick_evt;

  // events from synchronised second stages only; levels fall at frame end, ignored except by tick_evt, which takes both edges
  assign req_evt   = c_q.req_sync[1] & ~c_q.req_prev;
  assign start_evt = c_q.start_sync[1] & ~c_q.start_prev;
  assign tick_evt  = c_q.tick_sync[1] ^ c_q.tick_prev;
  assign cs_fall   = c_q.cs_prev & ~c_q.cs_sync[1];
  assign aclk_rise = c_q.aclk_sync[1] & ~c_q.aclk_prev;

  // power state sequencing
  always_comb begin
    c_d            = c_q;
    c_d.req_sync   = {c_q.req_sync[0], lnk.req_lvl};
    c_d.start_sync = {c_q.start_sync[0], lnk.start_lvl};
    c_d.tick_sync  = {c_q.tick_sync[0], lnk.tick_lvl};
    c_d.tick_prev  = c_q.tick_sync[1];
    c_d.cs_sync    = {c_q.cs_sync[0], i_cs_n};
    c_d.aclk_sync  = {c_q.aclk_sync[0], i_aclk};
    c_d.req_prev   = c_q.req_sync[1];
    c_d.start_prev = c_q.start_sync[1];
    c_d.cs_prev    = c_q.cs_sync[1];
    c_d.aclk_prev  = c_q.aclk_sync[1];
    c_d.conv_req   = 1'b0;
    unique case (c_q.st)
      ST_ACTIVE: begin
        if (req_evt) begin
          c_d.st         = ST_DUMMY;
          c_d.dcnt       = DUMMY_CYCLES;
          c_d.pend_start = 1'b0;
        end else if (cs_fall || start_evt) begin
          c_d.conv_req = 1'b1;
        end
      end
      ST_DUMMY: begin
        // a new burst or a select fall during the dummy conversion is held as a pending request while select stays low
        if (!c_q.cs_sync[1] && start_evt)
          c_d.pend_start = 1'b1;
        if (cs_fall)
          c_d.pend_start = 1'b1;
        if (c_q.cs_sync[1])
          c_d.pend_start = 1'b0;
        if (aclk_rise) begin
          if (c_q.dcnt <= 8'd1) begin
            c_d.dcnt = 8'd0;
            c_d.st   = ST_SLEEP;
          end else begin
            c_d.dcnt = c_q.dcnt - 8'd1;
          end
        end
      end
      ST_SLEEP: begin
        // wake and convert in the same cycle: no warm-up wait
        // clocks still running under low select after the dummy conversion wake us
        if (cs_fall || start_evt || c_q.pend_start ||
            (!c_q.cs_sync[1] && tick_evt)) begin
          c_d.st         = ST_ACTIVE;
          c_d.conv_req   = 1'b1;
          c_d.pend_start = 1'b0;
        end
      end
    endcase
  end

  // synchroniser resets leave select idle-high so no false falling edge
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      c_q            <= '0;
      c_q.cs_sync    <= 2'h3;
      c_q.cs_prev    <= 1'b1;
      c_q.st         <= ST_ACTIVE;
    end else begin
      c_q <= c_d;
    end
  end

  assign o_powered    = (c_q.st == ST_ACTIVE);
  assign o_dummy_busy = (c_q.st == ST_DUMMY);
  assign o_conv_req   = c_q.conv_req;
endmodule : pwr_shutdown_ctrl
`default_nettype wire

// ### core/pwrdn_pkg.sv
package pwrdn_pkg;
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_DUMMY,
    ST_SLEEP
  } pwr_state_t;
endpackage : pwrdn_pkg

// ### core/pwrdn_regs.svh
`ifndef PWRDN_REGS_SVH
`define PWRDN_REGS_SVH
// input word layout: 8 bits, msb first; word length field in bits 1:0
`define PWRDN_WORD_BITS      8
`define PWRDN_WL_UPPER_POS   1
`define PWRDN_WL_LOWER_POS   0
// shutdown code on the word length field: upper 0, lower 1
`define PWRDN_WL_UPPER_CODE  1'b0
`define PWRDN_WL_LOWER_CODE  1'b1
// shift clock on whose falling edge shutdown begins
`define PWRDN_ENTER_EDGE     5'd10
// conversion clock cycles taken by the dummy conversion
`define PWRDN_DUMMY_CYCLES   8'd12
`endif

// ### dv/host_port_model.sv
`timescale 1ns/1ps
`default_nettype none
// host serial port: sclk idles low, din changes ahead of each rising edge
module host_port_model (
  // link pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din  = 1'b0;
  end
  // n shift clocks, msb first; output data is never captured
  task automatic xfer(input logic [7:0] w, input int n, input bit raise);
    o_cs_n = 1'b0;
    for (int k = 0; k < n; k++) begin
      o_din = (k < 8) ? w[7-k] : 1'b0;
      #12 o_sclk = 1'b1;
      #24 o_sclk = 1'b0;
      #12;
    end
    o_din = ~o_din; // released line must not keep the last bit
    if (raise) o_cs_n = 1'b1;
  endtask : xfer
  // select pulse alone: a request by chip select falling
  task automatic wake();
    o_cs_n = 1'b0;
    #100 o_cs_n = 1'b1;
  endtask : wake
endmodule : host_port_model
`default_nettype wire

// ### dv/pwr_shutdown_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// power state checks on the top ports
module pwr_shutdown_ctrl_assertions #(
  parameter logic [7:0] DUMMY_CYCLES = 8'h0c
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  input wire logic i_aclk,
  input wire logic o_powered,
  input wire logic o_dummy_busy,
  input wire logic o_conv_req
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  sequence s_wake; $rose(o_powered); endsequence
  sequence s_asleep; !o_powered && !o_dummy_busy; endsequence
  a_wake_pulse: assert property (s_wake |-> o_conv_req) else $error("wake without request");
  a_req_single: assert property (o_conv_req |=> !o_conv_req) else $error("long request");
  a_cs_wake: assert property (($fell(i_cs_n) and s_asleep) |-> ##[1:6] o_powered)
    else $error("select fall did not wake");
  a_sleep_after: assert property ($fell(o_dummy_busy) |-> !o_powered) else $error("no sleep");
  a_busy_quiet: assert property (o_dummy_busy |-> !o_conv_req) else $error("request in dummy");
  a_dummy_ends: assert property ($rose(o_dummy_busy) |-> ##[1:40] $fell(o_dummy_busy))
    else $error("dummy conversion too long");
endmodule : pwr_shutdown_ctrl_assertions
bind pwr_shutdown_ctrl pwr_shutdown_ctrl_assertions #(.DUMMY_CYCLES(DUMMY_CYCLES)) chk_i (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_din(i_din),
  .i_aclk(i_aclk), .o_powered(o_powered), .o_dummy_busy(o_dummy_busy), .o_conv_req(o_conv_req));
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_mclk = 1'b0, i_srst = 1'b1, i_aclk = 1'b0, busy_seen = 1'b0, req_seen = 1'b0;
  wire logic sclk, cs_n, din;
  logic o_powered, o_dummy_busy, o_conv_req;
  logic [7:0] w;
  int num_errors = 0, n_compared = 0, seed = 89798, n;
  always #5 i_mclk = ~i_mclk;
  always #20 i_aclk = ~i_aclk; // free-running conversion clock
  host_port_model host_port_model_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
  pwr_shutdown_ctrl #(.DUMMY_CYCLES(8'h02)) pwr_shutdown_ctrl_i (.i_mclk(i_mclk),
    .i_srst(i_srst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din), .i_aclk(i_aclk),
    .o_powered(o_powered), .o_dummy_busy(o_dummy_busy), .o_conv_req(o_conv_req));
  // sticky flags so short pulses are not missed
  always @(posedge i_mclk) begin
    if (o_dummy_busy) busy_seen <= 1'b1;
    if (o_conv_req) req_seen <= 1'b1;
  end
  task automatic check(input string name, input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // shutdown only on code 01 and a tenth falling edge
  function automatic logic exp_sleep(input logic [7:0] v, input int c);
    return v[1:0] == 2'b01 && c >= 10;
  endfunction : exp_sleep
  task automatic run(input logic [7:0] v, input int c, input bit raise);
    @(negedge i_mclk);
    busy_seen = 1'b0;
    req_seen = 1'b0;
    if (c == 0) host_port_model_i.wake();
    else host_port_model_i.xfer(v, c, raise);
    repeat (30) @(negedge i_mclk);
  endtask : run
  initial begin
    repeat (12) @(negedge i_mclk);
    i_srst = 1'b0;
    check("powered", o_powered, 1'b1);
    run(8'h00, 0, 1'b1); // flush the first spurious link event
    for (int i = 0; i < 10; i++) begin
      w = (i < 2) ? 8'h3d : 8'($random(seed));
      n = 9 + (i & 1);
      run(w, n, 1'b1);
      check("dummy", busy_seen, exp_sleep(w, n));
      check("asleep", o_powered, !exp_sleep(w, n));
      if (!o_powered) begin
        run(8'h00, 0, 1'b1);
        check("wake", req_seen && o_powered, 1'b1);
      end
    end
    run(8'h3d, 16, 1'b0); // clocks outlast the dummy conversion
    check("late clocks", busy_seen && req_seen && o_powered, 1'b1);
    stop_test();
  end
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
